/* File: verilog/crsc_pkg.sv */
// package: shared states, timing and widths for the reset / sleep / management control link
`default_nettype none
package crsc_pkg;
    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int unsigned CRSC_CLK_HZ          = 20_000_000;   // bus clock rate
    localparam int unsigned CRSC_POR_RESET_US    = 2000;         // least power-on reset hold, in us
    localparam int unsigned CRSC_POR_RESET_CYC   = (CRSC_POR_RESET_US * (CRSC_CLK_HZ / 1_000_000));
    localparam int unsigned CRSC_BUS_RELEASE_CYC = 2;            // outputs released within this many clocks; the device takes three
    localparam int unsigned CRSC_PWR_SETTLE_CYC  = 16;           // supplies-stable wait before power valid

    // --------------------------------------------------------------------
    // processor power state
    // --------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CRSC_ST_RESET     = 3'b000,   // held in reset
        CRSC_ST_RUN       = 3'b001,   // executing
        CRSC_ST_HALT      = 3'b010,   // clock-halt: bus and interrupt units clocked
        CRSC_ST_SLEEP     = 3'b011,   // only the pll runs
        CRSC_ST_DEEP      = 3'b100,   // deep sleep
        CRSC_ST_MGMT_ACK  = 3'b101,   // issuing management acknowledge
        CRSC_ST_MGMT      = 3'b110,   // running management handler
        CRSC_ST_FLOAT     = 3'b111    // outputs tristated after reset
    } crsc_state_t;

    // host sequencer states
    typedef enum logic [1:0]
    {
        CRSC_H_OFF    = 2'b00,   // power not valid
        CRSC_H_SETTLE = 2'b01,   // waiting for supplies and clocks
        CRSC_H_RESET  = 2'b10,   // power valid, reset held
        CRSC_H_ON     = 2'b11    // reset released
    } crsc_hstate_t;
endpackage
`default_nettype wire

/* File: verilog/crsc_link_if.sv */
// interface: pins between system logic and the processor control block
`default_nettype none
interface crsc_link_if;
    logic power_valid;           // power-good level
    logic reset_n;               // hard reset, active low
    logic clock_halt_req_n;      // clock-halt request, active low
    logic sleep_req_n;           // sleep request, active low
    logic deep_sleep_req_n;      // deep-sleep request, active low
    logic mgmt_irq_n;            // management interrupt, active low
    logic warm_restart_n;        // self-test strap sampled at reset release
    logic bus_drive_oe;          // processor drives its bus outputs
    logic mgmt_ack;              // management acknowledge transaction pulse
    logic halt_ack;              // clock-halt acknowledge level

    // system logic end
    modport host
    (
        output power_valid, reset_n, clock_halt_req_n, sleep_req_n,
        output deep_sleep_req_n, mgmt_irq_n, warm_restart_n,
        input  bus_drive_oe, mgmt_ack, halt_ack
    );
    // processor end
    modport dev
    (
        input  power_valid, reset_n, clock_halt_req_n, sleep_req_n,
        input  deep_sleep_req_n, mgmt_irq_n, warm_restart_n,
        output bus_drive_oe, mgmt_ack, halt_ack
    );
endinterface
`default_nettype wire

/* File: verilog/crsc_device.sv */
// processor end: power-valid qualification, reset, halt/sleep states and management entry
`default_nettype none
// Summary of operation
// - system holds power-valid low until supplies stable
// - power-valid may drop; restabilise before rising
// - keep power-valid high during boundary scan
// - reset returns known state, caches invalidated
// - power-on reset held at least two milliseconds
// - bus outputs released within two clocks (here three: two synchroniser flops plus one register)
// - straps stable before reset release, latched then
// - sleep request in halt enters sleep
// - sleep ignores snoops and interrupts
// - sleep reacts only to reset, sleep release, deep-sleep request
// - sleep release returns to clock-halt
// - deep-sleep request in sleep enters deep sleep
// - management interrupt accepted asynchronously, enters management mode
// - acknowledge transaction, then run management handler
// - management interrupt at reset release floats outputs
// - halt keeps bus and interrupt units clocked
// - halt release restarts clocks, resumes execution
// - warm-restart at reset release runs self-test
module crsc_device
    import crsc_pkg::*;
#(
    parameter int unsigned CACHE_LINES = 16      // lines invalidated, one per clock, after reset release
)
(
    // clock and reset
    input  wire logic    clk_in,
    input  wire logic    resetn_in,
    // link to system logic
    crsc_link_if.dev     link,
    // processor core side
    input  wire logic    snoop_req_in,           // bus snoop request
    input  wire logic    intr_in,                // interrupt request
    output logic [2:0]   state_out,              // current power state
    output logic         core_clk_en_out,        // core units clocked
    output logic         bus_clk_en_out,         // bus and interrupt units clocked
    output logic         pll_on_out,             // pll running
    output logic         mgmt_mode_out,          // in management mode
    output logic         ctx_save_out,           // one-cycle pulse: save execution state
    output logic         cache_inval_out,        // cache invalidate in progress
    output logic         builtin_selftest_out,   // one-cycle pulse: start self-test
    output logic         snoop_ack_out,          // snoop serviced
    output logic         intr_ack_out            // interrupt serviced
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [6:0] meta_q;       // first stage, read only by sync_q
    logic [6:0] sync_q;       // second stage
    logic [6:0] raw_in;       // pin levels
    assign raw_in = {link.power_valid, link.reset_n, link.clock_halt_req_n, link.sleep_req_n,
                     link.deep_sleep_req_n, link.mgmt_irq_n, link.warm_restart_n};

    // two flops per pin before any logic looks at it
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            meta_q <= 7'h3e;  // power invalid, all requests idle
            sync_q <= 7'h3e;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end
    logic pv_s, rst_n_s, halt_n_s, slp_n_s, dslp_n_s, smi_n_s, warm_n_s;
    assign {pv_s, rst_n_s, halt_n_s, slp_n_s, dslp_n_s, smi_n_s, warm_n_s} = sync_q;
    // held in reset while power invalid or reset pin low
    logic hold_rst;
    assign hold_rst = !pv_s || !rst_n_s;

    // ------------------------------------------------------------------
    // state machine and outputs
    // ------------------------------------------------------------------
    crsc_state_t state_q, state_d;
    logic        smi_pend_q, smi_pend_d;   // latched management interrupt
    logic        smi_prev_q, smi_prev_d;   // edge detect on synchronised input
    logic        was_rst_q, was_rst_d;     // reset seen last cycle
    logic [$clog2(CACHE_LINES+1)-1:0] inval_q, inval_d;  // lines left to invalidate
    logic        oe_q, oe_d;
    logic        ack_q, ack_d;
    logic        save_q, save_d;
    logic        builtin_selftest_q, builtin_selftest_d;
    logic        snp_q, snp_d;
    logic        int_q, int_d;

    // next-state logic
    always_comb
    begin
        state_d    = state_q;
        smi_prev_d = smi_n_s;
        smi_pend_d = smi_pend_q;
        was_rst_d  = hold_rst;
        inval_d    = inval_q;
        oe_d       = oe_q;
        ack_d      = 1'b0;
        save_d     = 1'b0;
        builtin_selftest_d     = 1'b0;
        snp_d      = 1'b0;
        int_d      = 1'b0;
        // falling edge of management interrupt, captured in any awake state
        if (smi_prev_q && !smi_n_s)
            smi_pend_d = 1'b1;
        if (hold_rst)
        begin
            // known state, caches dropped without writeback, bus released
            state_d    = CRSC_ST_RESET;
            inval_d    = ($clog2(CACHE_LINES+1))'(CACHE_LINES);
            oe_d       = 1'b0;            // released one clock after sync
            smi_pend_d = 1'b0;
        end
        else
        begin
            if (inval_q != '0)
                inval_d = inval_q - 1'b1;   // invalidate one line per clock
            case (state_q)
                CRSC_ST_RESET:
                begin
                    // release edge: straps sampled here
                    if (was_rst_q)
                    begin
                        if (!smi_n_s)
                            state_d = CRSC_ST_FLOAT;
                        else
                        begin
                            state_d = CRSC_ST_RUN;
                            oe_d    = 1'b1;
                            builtin_selftest_d  = !warm_n_s;
                        end
                    end
                end
                CRSC_ST_FLOAT:
                    state_d = CRSC_ST_FLOAT;   // stays floating until next reset
                CRSC_ST_RUN:
                begin
                    snp_d = snoop_req_in;
                    int_d = intr_in;
                    if (smi_pend_q)
                    begin
                        save_d  = 1'b1;
                        state_d = CRSC_ST_MGMT_ACK;
                    end
                    else if (!halt_n_s)
                        state_d = CRSC_ST_HALT;
                end
                CRSC_ST_MGMT_ACK:
                begin
                    ack_d      = 1'b1;
                    smi_pend_d = smi_prev_q && !smi_n_s;   // fresh edge wins over clear
                    state_d    = CRSC_ST_MGMT;
                end
                CRSC_ST_MGMT:
                begin
                    snp_d = snoop_req_in;
                    int_d = intr_in;
                    if (!halt_n_s)
                        state_d = CRSC_ST_HALT;
                end
                CRSC_ST_HALT:
                begin
                    // bus and interrupt units keep running
                    snp_d = snoop_req_in;
                    int_d = intr_in;
                    if (!slp_n_s)
                        state_d = CRSC_ST_SLEEP;
                    else if (halt_n_s)
                        state_d = CRSC_ST_RUN;
                end
                CRSC_ST_SLEEP:
                begin
                    // snoops and interrupts not serviced; management edge dropped
                    smi_pend_d = smi_pend_q;
                    if (slp_n_s)
                        state_d = CRSC_ST_HALT;
                    else if (!dslp_n_s)
                        state_d = CRSC_ST_DEEP;
                end
                CRSC_ST_DEEP:
                begin
                    smi_pend_d = smi_pend_q;
                    if (dslp_n_s)
                        state_d = CRSC_ST_SLEEP;
                end
                default:
                    state_d = CRSC_ST_RESET;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            state_q    <= CRSC_ST_RESET;
            smi_pend_q <= 1'b0;
            smi_prev_q <= 1'b1;
            was_rst_q  <= 1'b1;
            inval_q    <= '0;
            oe_q       <= 1'b0;
            ack_q      <= 1'b0;
            save_q     <= 1'b0;
            builtin_selftest_q     <= 1'b0;
            snp_q      <= 1'b0;
            int_q      <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            smi_pend_q <= smi_pend_d;
            smi_prev_q <= smi_prev_d;
            was_rst_q  <= was_rst_d;
            inval_q    <= inval_d;
            oe_q       <= oe_d;
            ack_q      <= ack_d;
            save_q     <= save_d;
            builtin_selftest_q     <= builtin_selftest_d;
            snp_q      <= snp_d;
            int_q      <= int_d;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic core_q, bus_q, pll_q, mgmt_q, halt_q, cinv_q;

    // clock gates decoded from the next state, then registered once
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            core_q <= 1'b0;
            bus_q  <= 1'b0;
            pll_q  <= 1'b0;
            mgmt_q <= 1'b0;
            halt_q <= 1'b0;
            cinv_q <= 1'b0;
        end
        else
        begin
            core_q <= (state_d == CRSC_ST_RUN) || (state_d == CRSC_ST_MGMT) ||
                      (state_d == CRSC_ST_MGMT_ACK);
            bus_q  <= (state_d != CRSC_ST_SLEEP) && (state_d != CRSC_ST_DEEP) &&
                      (state_d != CRSC_ST_RESET);
            pll_q  <= (state_d != CRSC_ST_DEEP);
            mgmt_q <= (state_d == CRSC_ST_MGMT) || (state_d == CRSC_ST_MGMT_ACK) ||
                      (mgmt_q && state_d != CRSC_ST_RESET && state_d != CRSC_ST_RUN);
            halt_q <= (state_d == CRSC_ST_HALT);
            cinv_q <= (inval_d != '0);
        end
    end

    assign state_out            = state_q;
    assign core_clk_en_out      = core_q;
    assign bus_clk_en_out       = bus_q;
    assign pll_on_out           = pll_q;
    assign mgmt_mode_out        = mgmt_q;
    assign ctx_save_out         = save_q;
    assign cache_inval_out      = cinv_q;
    assign builtin_selftest_out = builtin_selftest_q;
    assign snoop_ack_out        = snp_q;
    assign intr_ack_out         = int_q;
    assign link.bus_drive_oe    = oe_q;
    assign link.mgmt_ack        = ack_q;
    assign link.halt_ack        = halt_q;
endmodule
`default_nettype wire

/* File: verilog/crsc_host.sv */
// system logic end: power-valid and reset sequencing, request pins
`default_nettype none
module crsc_host
    import crsc_pkg::*;
#(
    parameter int unsigned POR_CYC    = CRSC_POR_RESET_CYC,   // least reset hold in clocks
    parameter int unsigned SETTLE_CYC = CRSC_PWR_SETTLE_CYC   // supply settle wait
)
(
    // clock and reset
    input  wire logic    clk_in,
    input  wire logic    resetn_in,
    // link to processor
    crsc_link_if.host    link,
    // user side
    input  wire logic    supply_ok_in,     // supplies and clocks within spec
    input  wire logic    halt_req_in,      // request clock halt
    input  wire logic    sleep_req_in,     // request sleep
    input  wire logic    deep_req_in,      // request deep sleep
    input  wire logic    mgmt_req_in,      // request management interrupt
    input  wire logic    selftest_req_in,  // warm-restart strap value
    output logic         in_reset_out,     // reset still held
    output logic         halt_ack_out,     // processor in clock-halt
    output logic         mgmt_ack_out      // management acknowledge seen
);
    crsc_hstate_t st_q, st_d;
    logic [31:0]  cnt_q, cnt_d;
    logic [6:0]   pin_q, pin_d;   // {pv, rst_n, halt_n, slp_n, dslp_n, smi_n, warm_n}
    logic [1:0]   ack_q, ack_d;

    // sequencer: power valid only after settle, reset held the full time
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        ack_d = {link.halt_ack, link.mgmt_ack};
        pin_d = {1'b0, 1'b0, !halt_req_in, !sleep_req_in, !deep_req_in, !mgmt_req_in, !selftest_req_in};
        case (st_q)
            CRSC_H_OFF:
            begin
                cnt_d = 32'h0;
                if (supply_ok_in)
                    st_d = CRSC_H_SETTLE;
            end
            CRSC_H_SETTLE:
            begin
                cnt_d = cnt_q + 32'h1;
                if (!supply_ok_in)
                    st_d = CRSC_H_OFF;
                else if (cnt_q >= 32'(SETTLE_CYC))
                begin
                    st_d  = CRSC_H_RESET;                  // clean monotonic rise
                    cnt_d = 32'h0;
                end
            end
            CRSC_H_RESET:
            begin
                pin_d[6] = 1'b1;                           // power valid stays high
                cnt_d    = cnt_q + 32'h1;
                if (!supply_ok_in)
                    st_d = CRSC_H_OFF;
                else if (cnt_q >= 32'(POR_CYC))
                    st_d = CRSC_H_ON;                      // straps already stable
            end
            CRSC_H_ON:
            begin
                pin_d[6] = 1'b1;
                pin_d[5] = 1'b1;
                if (!supply_ok_in)
                    st_d = CRSC_H_OFF;
            end
            default:
                st_d = CRSC_H_OFF;
        endcase
    end

    // registers
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            st_q  <= CRSC_H_OFF;
            cnt_q <= 32'h0;
            pin_q <= 7'h1f;
            ack_q <= 2'h0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d;
            ack_q <= ack_d;
        end
    end

    assign {link.power_valid, link.reset_n, link.clock_halt_req_n, link.sleep_req_n,
            link.deep_sleep_req_n, link.mgmt_irq_n, link.warm_restart_n} = pin_q;
    assign in_reset_out = !pin_q[5];
    assign halt_ack_out = ack_q[1];
    assign mgmt_ack_out = ack_q[0];
endmodule
`default_nettype wire

/* File: dv/crsc_properties.sv */
// checker: timing properties of the reset / sleep / management link pins
`default_nettype none
module crsc_properties
    import crsc_pkg::*;
#(
    parameter int unsigned POR_CYC = CRSC_POR_RESET_CYC   // least reset hold in clocks
)
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic resetn_in,
    // link pins
    input  wire logic power_valid,
    input  wire logic reset_n,
    input  wire logic clock_halt_req_n,
    input  wire logic mgmt_irq_n,
    input  wire logic bus_drive_oe,
    input  wire logic mgmt_ack,
    input  wire logic halt_ack
);
    // ------------------------------------------------------------
    // reset hold counter
    // ------------------------------------------------------------
    logic [15:0] por_q;   // clocks of reset held with power valid
    logic [15:0] por_d;   // next count

    // saturates so a long hold never wraps into a short one
    always_comb
    begin
        por_d = 16'h0000;
        if (power_valid && !reset_n)
            por_d = (por_q == 16'hffff) ? por_q : por_q + 16'h0001;
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
            por_q <= 16'h0000;
        else
            por_q <= por_d;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_pv_first: assert property ($rose(power_valid) |-> !reset_n)
        else $error("reset not held as power became valid");
    // one clock of slack: the count starts on the first sampled edge
    a_por_hold: assert property ($rose(reset_n) |-> por_q >= POR_CYC - 1)
        else $error("reset released too early after power valid");
    // two synchroniser flops plus one register
    a_bus_release: assert property (!reset_n [*4] |-> !bus_drive_oe)
        else $error("bus outputs still driven during reset");
    a_pv_low_hold: assert property (!power_valid [*4] |-> !bus_drive_oe && !halt_ack && !mgmt_ack)
        else $error("device active while power not valid");
    a_ack_pulse: assert property (mgmt_ack |=> !mgmt_ack)
        else $error("management acknowledge longer than one clock");
    a_ack_cause: assert property (mgmt_ack |-> !$past(mgmt_irq_n, 2))
        else $error("management acknowledge without interrupt");
    a_halt_cause: assert property ($rose(halt_ack) |-> !$past(clock_halt_req_n, 2))
        else $error("halt entered without request");
    a_halt_exit: assert property (clock_halt_req_n [*5] |-> !halt_ack)
        else $error("halt held after request released");
    a_float_out: assert property ($rose(reset_n) && power_valid && !mgmt_irq_n && !$past(mgmt_irq_n, 3)
        |-> ##2 (!bus_drive_oe) [*6])
        else $error("outputs driven after reset with management interrupt");
    a_run_after: assert property ($rose(reset_n) && power_valid && mgmt_irq_n && $past(mgmt_irq_n, 3)
        |-> ##[2:4] bus_drive_oe)
        else $error("device not running after reset release");
endmodule
`default_nettype wire

/* File: dv/test_cpu_reset_sleep_smi_control.sv */
// testbench: both ends of the reset / sleep / management link against a state model
`default_nettype none
module test_cpu_reset_sleep_smi_control
    import crsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    localparam int POR   = 20;     // short reset hold
    localparam int LIMIT = 3000;   // clocks before a hang is cut short
    logic        clk_in       = 1'b0;
    logic        resetn_in    = 1'b0;
    logic        supply_ok    = 1'b0;   // host user inputs
    logic        halt_req     = 1'b0;
    logic        sleep_req    = 1'b0;
    logic        deep_req     = 1'b0;
    logic        mgmt_req     = 1'b0;
    logic        selftest_req = 1'b0;
    logic        snoop_req    = 1'b0;   // device core inputs
    logic        intr_req     = 1'b0;
    logic [2:0]  state;                 // device outputs
    logic        core_en, bus_en, pll_on, mgmt_mode, ctx_save, cache_inval, builtin_selftest_go, snoop_ack, intr_ack;
    logic        in_reset, halt_seen, ack_seen;   // host outputs
    int          n_fail = 0, n_tests = 0, cycles = 0, seed = 32'h9bcb;
    int          n_builtin_selftest = 0, n_ctx = 0, n_ack = 0, n_inval = 0;   // pulse counts; n_inval counts clocks of cache invalidate
    crsc_state_t exp_st = CRSC_ST_RESET;   // model state
    logic [31:0] r;                        // random draw

    crsc_link_if link ();
    crsc_host #(.POR_CYC(POR), .SETTLE_CYC(16)) crsc_host_i
    (
        .clk_in(clk_in), .resetn_in(resetn_in), .link(link), .supply_ok_in(supply_ok),
        .halt_req_in(halt_req), .sleep_req_in(sleep_req), .deep_req_in(deep_req), .mgmt_req_in(mgmt_req),
        .selftest_req_in(selftest_req), .in_reset_out(in_reset), .halt_ack_out(halt_seen),
        .mgmt_ack_out(ack_seen)
    );
    crsc_device #(.CACHE_LINES(16)) crsc_device_i
    (
        .clk_in(clk_in), .resetn_in(resetn_in), .link(link), .snoop_req_in(snoop_req), .intr_in(intr_req),
        .state_out(state), .core_clk_en_out(core_en), .bus_clk_en_out(bus_en), .pll_on_out(pll_on),
        .mgmt_mode_out(mgmt_mode), .ctx_save_out(ctx_save), .cache_inval_out(cache_inval),
        .builtin_selftest_out(builtin_selftest_go), .snoop_ack_out(snoop_ack), .intr_ack_out(intr_ack)
    );
    crsc_properties #(.POR_CYC(POR)) crsc_properties_i
    (
        .clk_in(clk_in), .resetn_in(resetn_in), .power_valid(link.power_valid), .reset_n(link.reset_n),
        .clock_halt_req_n(link.clock_halt_req_n), .mgmt_irq_n(link.mgmt_irq_n),
        .bus_drive_oe(link.bus_drive_oe), .mgmt_ack(link.mgmt_ack), .halt_ack(link.halt_ack)
    );

    // ------------------------------------------------------------
    // clock, pulse counters and hang guard
    // ------------------------------------------------------------
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end

    // one-clock pulses are counted, not sampled
    always @(posedge clk_in)
    begin
        cycles++;
        n_builtin_selftest  += (builtin_selftest_go === 1'b1);
        n_ctx   += (ctx_save === 1'b1);
        n_ack   += (ack_seen === 1'b1);
        n_inval += (cache_inval === 1'b1);
        if (cycles == LIMIT)
        begin
            n_fail++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // model and checking tasks
    // ------------------------------------------------------------
    // power states; others hold until reset
    function automatic crsc_state_t nxt(input crsc_state_t st, input logic h, s, d, m);
        case (st)
            CRSC_ST_RUN:   return m ? CRSC_ST_MGMT : (h ? CRSC_ST_HALT : CRSC_ST_RUN);
            CRSC_ST_HALT:  return s ? CRSC_ST_SLEEP : (h ? CRSC_ST_HALT : CRSC_ST_RUN);
            CRSC_ST_SLEEP: return d ? CRSC_ST_DEEP : (s ? CRSC_ST_SLEEP : CRSC_ST_HALT);
            CRSC_ST_DEEP:  return d ? CRSC_ST_DEEP : CRSC_ST_SLEEP;
            default:       return st;
        endcase
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // dwell shows ignored requests, then bounded wait
    task automatic settle();
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 200 && state !== 3'(exp_st); i++) @(posedge clk_in);
        #1;
        chk("state", {5'h00, state}, 8'(exp_st)); // power state follows the model
    endtask

    task automatic go(input logic h, s, d, m);
        @(posedge clk_in);
        halt_req  <= h;
        sleep_req <= s;
        deep_req  <= d;
        mgmt_req  <= m;
        exp_st = nxt(exp_st, h, s, d, m);
        settle();
        chk("core_clk", {7'h00, core_en}, {7'h00, exp_st inside {CRSC_ST_RUN, CRSC_ST_MGMT}});
        chk("bus_clk", {7'h00, bus_en},
            {7'h00, exp_st inside {CRSC_ST_RUN, CRSC_ST_HALT, CRSC_ST_MGMT, CRSC_ST_FLOAT}});
        chk("halt_ack", {7'h00, halt_seen}, {7'h00, exp_st == CRSC_ST_HALT});
        chk("mgmt_mode", {7'h00, mgmt_mode}, {7'h00, exp_st == CRSC_ST_MGMT});
        if (exp_st == CRSC_ST_SLEEP)
            chk("pll_on", {7'h00, pll_on}, 8'h01); // only the pll keeps running
        // snoops, interrupts served in halt, not in sleep or deep sleep
        if (exp_st inside {CRSC_ST_HALT, CRSC_ST_SLEEP, CRSC_ST_DEEP})
        begin
            r = $random(seed);
            @(posedge clk_in);
            snoop_req <= r[0];
            intr_req  <= r[1];
            repeat (3) @(posedge clk_in);
            #1;
            chk("snoop_ack", {7'h00, snoop_ack}, {7'h00, r[0] & (exp_st == CRSC_ST_HALT)});
            chk("intr_ack", {7'h00, intr_ack}, {7'h00, r[1] & (exp_st == CRSC_ST_HALT)});
            @(posedge clk_in);
            snoop_req <= 1'b0;
            intr_req  <= 1'b0;
        end
    endtask

    task automatic pwr(input logic on, m, b);
        @(posedge clk_in);
        supply_ok    <= on;
        mgmt_req     <= m;
        selftest_req <= b;
        n_builtin_selftest  = 0;
        n_inval = 0;
        exp_st = !on ? CRSC_ST_RESET : (m ? CRSC_ST_FLOAT : CRSC_ST_RUN);
        settle();
        chk("bus_oe", {7'h00, link.bus_drive_oe}, {7'h00, exp_st == CRSC_ST_RUN});
        chk("in_reset", {7'h00, in_reset}, {7'h00, !on});
        if (exp_st == CRSC_ST_RUN)
        begin
            chk("selftest", 8'(n_builtin_selftest), {7'h00, b}); // one self-test pulse when strapped
            chk("cache_inval", {7'h00, n_inval > 0}, 8'h01); // caches cleared during reset
        end
    endtask

    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        pwr(1'b1, 1'b0, 1'b1);
        $display("done: power up");
        go(1'b1, 1'b0, 1'b0, 1'b0);
        go(1'b1, 1'b1, 1'b0, 1'b0);
        n_ack = 0;
        go(1'b1, 1'b1, 1'b0, 1'b1);   // management request while asleep
        go(1'b1, 1'b1, 1'b0, 1'b0);
        chk("mgmt_in_sleep", 8'(n_ack), 8'h00); // interrupt ignored while asleep
        go(1'b1, 1'b1, 1'b1, 1'b0);
        go(1'b1, 1'b1, 1'b0, 1'b0);
        go(1'b1, 1'b0, 1'b0, 1'b0);
        go(1'b0, 1'b0, 1'b0, 1'b0);
        $display("done: sleep chain");
        n_ctx = 0;
        n_ack = 0;
        go(1'b0, 1'b0, 1'b0, 1'b1);
        go(1'b0, 1'b0, 1'b0, 1'b0);
        chk("ctx_save", 8'(n_ctx), 8'h01); // state saved once on entry
        chk("mgmt_ack", 8'(n_ack), 8'h01); // one acknowledge transaction
        $display("done: management interrupt");
        pwr(1'b0, 1'b0, 1'b0);
        $display("done: power dropped");
        pwr(1'b1, 1'b1, 1'b0);
        go(1'b0, 1'b0, 1'b0, 1'b0);
        $display("done: float at reset");
        test_done();
    end
endmodule
`default_nettype wire
